// ===== hdl/fp_access_pkg.sv
// shared constants, format codes and decode functions for the float register access block
package fp_access_pkg;

    ////////////////////////////////////////////////////////////////////////////////
    // register file shape
    localparam int fpr_count     = 32;
    localparam int fpr_num_width = 5;
    localparam int fpr_width     = 64;
    localparam int half_width    = 32;

    ////////////////////////////////////////////////////////////////////////////////
    // format codes presented by the pipeline
    localparam logic [3:0] fmt_single     = 4'h0;
    localparam logic [3:0] fmt_double     = 4'h1;
    localparam logic [3:0] fmt_word       = 4'h2;
    localparam logic [3:0] fmt_long       = 4'h3;
    localparam logic [3:0] fmt_paired     = 4'h4;
    localparam logic [3:0] fmt_octal_byte = 4'h5;
    localparam logic [3:0] fmt_quad_half  = 4'h6;
    localparam logic [3:0] fmt_raw_word   = 4'h7;
    localparam logic [3:0] fmt_raw_double = 4'h8;

    typedef enum logic [1:0] {
        class_word,
        class_double,
        class_wide,
        class_bad
    } fmt_class_type;

    ////////////////////////////////////////////////////////////////////////////////
    // control/status word fields
    localparam int csr_unimpl_bit = 17;
    localparam int csr_cause_lo   = 12;
    localparam int csr_cause_hi   = 16;
    localparam int csr_enable_lo  = 7;
    localparam int csr_enable_hi  = 11;
    localparam int csr_flag0_bit  = 23;
    localparam int csr_flag_base  = 24;

    ////////////////////////////////////////////////////////////////////////////////
    // bus map, byte addresses
    localparam logic [7:0] off_mode       = 8'h00;
    localparam logic [7:0] off_csr        = 8'h04;
    localparam logic [7:0] off_irq_status = 8'h08;
    localparam logic [7:0] off_irq_mask   = 8'h0C;
    localparam logic [7:0] off_state      = 8'h10;

    // interrupt status bit positions
    localparam int irq_trap_bit  = 0;
    localparam int irq_unpre_bit = 1;

    ////////////////////////////////////////////////////////////////////////////////
    // values after reset
    localparam logic [31:0] csr_reset  = 32'h0000_0000;
    localparam logic        mode_reset = 1'b0;
    localparam logic [1:0]  irq_reset  = 2'h0;

    function automatic fmt_class_type fmt_class(input logic [3:0] fmt);
        if (fmt == fmt_single || fmt == fmt_word || fmt == fmt_raw_word) begin
            return class_word;
        end else if (fmt == fmt_double || fmt == fmt_raw_double) begin
            return class_double;
        end else if (fmt == fmt_long || fmt == fmt_paired || fmt == fmt_octal_byte || fmt == fmt_quad_half) begin
            return class_wide;
        end else begin
            return class_bad;
        end
    endfunction

    // csr bit that holds a compare flag; flag 0 is set apart from the rest
    function automatic logic [4:0] flag_bit(input logic [2:0] num);
        if (num == 3'h0) begin
            return 5'(csr_flag0_bit);
        end else begin
            return 5'(csr_flag_base) + {2'h0, num};
        end
    endfunction

endpackage

// ===== hdl/fpr_port_if.sv
// port bundle between the access logic and the float register array
`timescale 1ns/1ps
interface fpr_port_if;
    import fp_access_pkg::*;

    logic [fpr_num_width-1:0] wr_num;
    logic                     wr_lo_en;
    logic [fpr_width-1:0]     wr_lo_data;
    logic                     wr_hi_en;
    logic [fpr_width-1:0]     wr_hi_data;
    logic [fpr_num_width-1:0] rd_num;
    logic [fpr_width-1:0]     rd_lo;
    logic [fpr_width-1:0]     rd_hi;

    modport store (
        input  wr_num, wr_lo_en, wr_lo_data, wr_hi_en, wr_hi_data, rd_num,
        output rd_lo, rd_hi
    );
    modport access (
        output wr_num, wr_lo_en, wr_lo_data, wr_hi_en, wr_hi_data, rd_num,
        input  rd_lo, rd_hi
    );
endinterface // fpr_port_if

// ===== hdl/fpr_array.sv
// float register array: one addressed register plus its upper neighbour per access
`timescale 1ns/1ps
module fpr_array
    import fp_access_pkg::*;
#(
    parameter int count = fpr_count
) (
    // clock
    input wire logic  clk,
    // access port
    fpr_port_if.store port
);
    import fp_access_pkg::*;

    logic [fpr_width-1:0]     regs [count];
    logic [fpr_num_width-1:0] hi_num;
    logic [fpr_num_width-1:0] rd_hi_num;

    // pair partner wraps at the top; only even numbers pair, so it never does
    assign hi_num    = port.wr_num + 5'h1;
    assign rd_hi_num = port.rd_num + 5'h1;

    always_ff @(posedge clk) begin
        if (port.wr_lo_en) begin
            regs[port.wr_num] <= port.wr_lo_data;
        end
        if (port.wr_hi_en) begin
            regs[hi_num] <= port.wr_hi_data;
        end
    end

    assign port.rd_lo = regs[port.rd_num];
    assign port.rd_hi = regs[rd_hi_num];

endmodule // fpr_array

// ===== hdl/fp_status_check.sv
// trap detection and compare flag selection from the control/status word
`timescale 1ns/1ps
module fp_status_check
    import fp_access_pkg::*;
(
    // clock and reset
    input  wire logic        clk,
    input  wire logic        nrst,
    // control/status word
    input  wire logic [31:0] csr_word,
    // flag selection
    input  wire logic [2:0]  flag_num,
    // results
    output logic             trap_now,
    output logic             flag_sel
);
    import fp_access_pkg::*;

    logic [4:0] cause_and_enable;

    assign cause_and_enable = csr_word[csr_cause_hi:csr_cause_lo] & csr_word[csr_enable_hi:csr_enable_lo];
    // unimplemented operation has no enable, so it always traps
    assign trap_now = csr_word[csr_unimpl_bit] | (|cause_and_enable);
    assign flag_sel = csr_word[flag_bit(flag_num)];

    // trap_now feeds a register one level up, so the check runs on the same edge
    property p_unimpl_traps;
        @(posedge clk) disable iff (!nrst)
        csr_word[csr_unimpl_bit] |-> trap_now;
    endproperty
    a_unimpl_traps : assert property (p_unimpl_traps) else $error("unimplemented cause set without trap");

    property p_enabled_traps;
        @(posedge clk) disable iff (!nrst)
        (csr_word[16] & csr_word[11]) | (csr_word[15] & csr_word[10]) | (csr_word[14] & csr_word[9])
            | (csr_word[13] & csr_word[8]) | (csr_word[12] & csr_word[7]) |-> trap_now;
    endproperty
    a_enabled_traps : assert property (p_enabled_traps) else $error("enabled cause without trap");

endmodule // fp_status_check

// ===== hdl/fp_register_format_access.sv
// formatted float register access, status word, compare flags and bus slave
`timescale 1ns/1ps
// Overview of operation
// - a single, word or raw-word read returns the low half of the register, upper half here reads zero.
// - in pair mode a doubleword read of an even register joins the next register's low half above its own.
// - a single, word or raw-word write stores bits 31..0 in the low half, upper half here written zero.
// - in pair mode a doubleword write to an even register splits bits 31..0 and 63..32 over the pair.
// - in pair mode a doubleword access to an odd register is unpredictable: no write, zero read, flagged.
// - long, paired, octal-byte and quad-half formats are unpredictable in pair mode, else full 64-bit moves.
// - a read with an undefined format code returns an unpredictable value, here zero and flagged.
// - a set unimplemented-operation cause bit 17 always raises the trap.
// - any cause bit 16..12 set together with its enable bit 11..7 raises the trap.
// - eight compare flags are read from bit 23 for flag 0 and bit 24 plus n for the others.
// - the pipeline may write a new value into one compare flag chosen by its number.
module fp_register_format_access
    import fp_access_pkg::*;
(
    // clock and reset
    input  wire logic                           clk,
    input  wire logic                           nrst,
    // register bus
    input  wire logic [7:0]                     address,
    input  wire logic                           read,
    input  wire logic                           write,
    input  wire logic [31:0]                    writedata,
    input  wire logic [3:0]                     byteenable,
    output logic [31:0]                         readdata,
    output logic                                waitrequest,
    output logic                                irq,
    // pipeline register access
    input  wire logic                           acc_valid,
    input  wire logic                           acc_write,
    input  wire logic [fp_access_pkg::fpr_num_width-1:0] acc_num,
    input  wire logic [3:0]                     acc_fmt,
    input  wire logic [63:0]                    acc_wdata,
    output logic                                acc_done,
    output logic [63:0]                         acc_rdata,
    output logic                                acc_unpredictable,
    // compare flags and trap
    input  wire logic [2:0]                     flag_num,
    input  wire logic                           flag_write,
    input  wire logic                           flag_wvalue,
    output logic                                flag_value,
    output logic                                trap
);
    import fp_access_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // state
    logic [31:0]          csr_word;
    logic                 narrow_register_mode;
    logic [1:0]           irq_status;
    logic [1:0]           irq_mask;
    logic                 ack;
    logic                 bus_wr;
    logic                 bus_rd;
    logic [31:0]          wmask;
    logic [31:0]          next_readdata;
    logic [63:0]          next_rdata;
    logic                 next_unpre;
    logic                 trap_now;
    logic                 flag_sel;
    logic [31:0]          flag_mask;
    fmt_class_type        acc_class;
    logic [31:0]          lo32;
    logic [31:0]          hi32;

    fpr_port_if fpr_if ();

    fpr_array #(
        .count (fpr_count)
    ) u_array (
        .clk  (clk),
        .port (fpr_if.store)
    );

    fp_status_check u_check (
        .clk      (clk),
        .nrst     (nrst),
        .csr_word (csr_word),
        .flag_num (flag_num),
        .trap_now (trap_now),
        .flag_sel (flag_sel)
    );

    function automatic logic [31:0] lane_mask(input logic [3:0] be);
        return {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // bus slave: one wait cycle, read data captured while waitrequest is high, write data once it drops
    assign waitrequest = (read | write) & ~ack;
    assign bus_wr      = write & ack;
    assign bus_rd      = read & ~ack;
    assign wmask       = lane_mask(byteenable) & writedata;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            ack <= 1'b0;
        end else begin
            ack <= (read | write) & ~ack;
        end
    end

    always_comb begin
        if (address == off_mode) begin
            next_readdata = {31'h0000_0000, narrow_register_mode};
        end else if (address == off_csr) begin
            next_readdata = csr_word;
        end else if (address == off_irq_status) begin
            next_readdata = {30'h0000_0000, irq_status};
        end else if (address == off_irq_mask) begin
            next_readdata = {30'h0000_0000, irq_mask};
        end else if (address == off_state) begin
            next_readdata = {30'h0000_0000, flag_value, trap};
        end else begin
            next_readdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            readdata <= 32'h0000_0000;
        end else if (bus_rd) begin
            readdata <= next_readdata;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            narrow_register_mode <= mode_reset;
        end else if (bus_wr && address == off_mode && byteenable[0]) begin
            narrow_register_mode <= writedata[0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control/status word; a flag write from the pipeline lands after the bus write
    assign flag_mask = 32'h0000_0001 << flag_bit(flag_num);

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            csr_word <= csr_reset;
        end else begin
            if (bus_wr && address == off_csr) begin
                if (flag_write) begin
                    csr_word <= ((csr_word & ~lane_mask(byteenable)) | wmask) & ~flag_mask
                                | ({32{flag_wvalue}} & flag_mask);
                end else begin
                    csr_word <= (csr_word & ~lane_mask(byteenable)) | wmask;
                end
            end else if (flag_write) begin
                csr_word <= (csr_word & ~flag_mask) | ({32{flag_wvalue}} & flag_mask);
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            trap       <= 1'b0;
            flag_value <= 1'b0;
        end else begin
            trap       <= trap_now;
            flag_value <= flag_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // interrupts: set wins over a write-one clear in the same cycle
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_status <= irq_reset;
        end else begin
            irq_status[irq_trap_bit] <= (irq_status[irq_trap_bit] & ~(bus_wr && address == off_irq_status
                                        && byteenable[0] && writedata[irq_trap_bit])) | (trap_now & ~trap);
            irq_status[irq_unpre_bit] <= (irq_status[irq_unpre_bit] & ~(bus_wr && address == off_irq_status
                                         && byteenable[0] && writedata[irq_unpre_bit])) | (acc_valid & next_unpre);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            irq_mask <= irq_reset;
        end else if (bus_wr && address == off_irq_mask && byteenable[0]) begin
            irq_mask <= writedata[1:0];
        end
    end

    assign irq = |(irq_status & irq_mask);

    ////////////////////////////////////////////////////////////////////////////////
    // formatted access; unpredictable results read zero and never touch the array
    assign acc_class     = fmt_class(acc_fmt);
    assign fpr_if.wr_num = acc_num;
    assign fpr_if.rd_num = acc_num;
    assign lo32          = fpr_if.rd_lo[31:0];
    assign hi32          = fpr_if.rd_hi[31:0];

    always_comb begin
        fpr_if.wr_lo_en   = 1'b0;
        fpr_if.wr_hi_en   = 1'b0;
        fpr_if.wr_lo_data = acc_wdata;
        fpr_if.wr_hi_data = {32'h0000_0000, acc_wdata[63:32]};
        next_rdata        = 64'h0000_0000_0000_0000;
        next_unpre        = 1'b0;
        case (acc_class)
            class_word: begin
                fpr_if.wr_lo_data = {32'h0000_0000, acc_wdata[31:0]};
                fpr_if.wr_lo_en   = acc_valid & acc_write;
                next_rdata        = {32'h0000_0000, lo32};
            end
            class_double: begin
                if (!narrow_register_mode && acc_num[0]) begin
                    next_unpre = 1'b1;
                end else if (!narrow_register_mode) begin
                    fpr_if.wr_lo_data = {32'h0000_0000, acc_wdata[31:0]};
                    fpr_if.wr_lo_en   = acc_valid & acc_write;
                    fpr_if.wr_hi_en   = acc_valid & acc_write;
                    next_rdata        = {hi32, lo32};
                end else begin
                    fpr_if.wr_lo_en = acc_valid & acc_write;
                    next_rdata      = fpr_if.rd_lo;
                end
            end
            class_wide: begin
                if (!narrow_register_mode) begin
                    next_unpre = 1'b1;
                end else begin
                    fpr_if.wr_lo_en = acc_valid & acc_write;
                    next_rdata      = fpr_if.rd_lo;
                end
            end
            default: begin
                // an unknown format on a write is dropped and flagged unpredictable
                next_unpre = 1'b1;
            end
        endcase
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            acc_done          <= 1'b0;
            acc_unpredictable <= 1'b0;
            acc_rdata         <= 64'h0000_0000_0000_0000;
        end else begin
            acc_done          <= acc_valid;
            acc_unpredictable <= acc_valid & next_unpre;
            if (acc_valid && !acc_write) begin
                acc_rdata <= next_rdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    sequence s_read_req(fmt_class_type c);
        acc_valid && !acc_write && acc_class == c;
    endsequence

    sequence s_odd_pair;
        acc_valid && !narrow_register_mode && acc_class == class_double && acc_num[0];
    endsequence

    property p_word_read;
        @(posedge clk) disable iff (!nrst)
        s_read_req(class_word) |=> acc_rdata[31:0] == $past(lo32) && acc_done;
    endproperty
    a_word_read : assert property (p_word_read) else $error("word read lost low half");

    property p_pair_read;
        @(posedge clk) disable iff (!nrst)
        s_read_req(class_double) and (!narrow_register_mode && !acc_num[0])
            |=> acc_rdata == {$past(hi32), $past(lo32)};
    endproperty
    a_pair_read : assert property (p_pair_read) else $error("pair read misassembled");

    property p_word_write;
        @(posedge clk) disable iff (!nrst)
        acc_valid && acc_write && acc_class == class_word
            |-> fpr_if.wr_lo_en && !fpr_if.wr_hi_en && fpr_if.wr_lo_data[31:0] == acc_wdata[31:0];
    endproperty
    a_word_write : assert property (p_word_write) else $error("word write misplaced");

    property p_pair_write;
        @(posedge clk) disable iff (!nrst)
        acc_valid && acc_write && acc_class == class_double && !narrow_register_mode && !acc_num[0]
            |-> fpr_if.wr_lo_en && fpr_if.wr_hi_en && fpr_if.wr_hi_data[31:0] == acc_wdata[63:32];
    endproperty
    a_pair_write : assert property (p_pair_write) else $error("pair write not split");

    property p_odd_pair;
        @(posedge clk) disable iff (!nrst)
        s_odd_pair |-> !fpr_if.wr_lo_en && !fpr_if.wr_hi_en ##1 acc_unpredictable && irq_status[irq_unpre_bit];
    endproperty
    a_odd_pair : assert property (p_odd_pair) else $error("odd pair access not refused");

    property p_wide_move;
        @(posedge clk) disable iff (!nrst)
        s_read_req(class_wide) and narrow_register_mode |=> acc_rdata == $past(fpr_if.rd_lo) && !acc_unpredictable;
    endproperty
    a_wide_move : assert property (p_wide_move) else $error("wide read not full width");

    property p_bad_read;
        @(posedge clk) disable iff (!nrst)
        s_read_req(class_bad) |=> acc_unpredictable && acc_rdata == 64'h0000_0000_0000_0000;
    endproperty
    a_bad_read : assert property (p_bad_read) else $error("undefined format not flagged");

    property p_trap_follows;
        @(posedge clk) disable iff (!nrst)
        csr_word[csr_unimpl_bit] |=> trap;
    endproperty
    a_trap_follows : assert property (p_trap_follows) else $error("trap output missed cause");

    property p_flag_read;
        @(posedge clk) disable iff (!nrst)
        flag_num == 3'h0 |=> flag_value == $past(csr_word[csr_flag0_bit]);
    endproperty
    a_flag_read : assert property (p_flag_read) else $error("flag 0 not from bit 23");

    property p_flag_write;
        @(posedge clk) disable iff (!nrst)
        flag_write && !bus_wr |=> csr_word == (($past(csr_word) & ~$past(flag_mask))
                                  | ({32{$past(flag_wvalue)}} & $past(flag_mask)));
    endproperty
    a_flag_write : assert property (p_flag_write) else $error("flag write touched other bits");

endmodule // fp_register_format_access

// ===== bench/fp_pipe_model.sv
// pipeline-side model issuing float register accesses and compare flag writes
`timescale 1ns/1ps
module fp_pipe_model (
    // clock
    input  wire logic                               clk,
    // register access
    output logic                                    acc_valid,
    output logic                                    acc_write,
    output logic [fp_access_pkg::fpr_num_width-1:0] acc_num,
    output logic [3:0]                              acc_fmt,
    output logic [63:0]                             acc_wdata,
    input  wire logic                               acc_done,
    input  wire logic [63:0]                        acc_rdata,
    input  wire logic                               acc_unpredictable,
    // compare flags
    output logic [2:0]                              flag_num,
    output logic                                    flag_write,
    output logic                                    flag_wvalue
);
    import fp_access_pkg::*;
    initial begin
        {acc_valid, acc_write, acc_num, acc_fmt, acc_wdata} = '0;
        {flag_num, flag_write, flag_wvalue} = '0;
    end
    ////////////////////////////////////////////////////////////////////////////////
    // one pulse per access; callers may read a value back in another format than it was written with
    task automatic access(input logic w, input logic [4:0] n, input logic [3:0] f, input logic [63:0] d,
                          output logic [63:0] q, output logic u, output logic ok);
        int i;
        @(posedge clk);
        acc_valid <= 1'b1;
        acc_write <= w;
        acc_num   <= n;
        acc_fmt   <= f;
        acc_wdata <= d;
        @(posedge clk);
        acc_valid <= 1'b0;
        // stale data would hide a missed capture
        acc_wdata <= ~d;
        for (i = 0; i < 4; i++) begin
            @(negedge clk);
            if (acc_done === 1'b1) break;
        end
        ok = (i < 4);
        q  = acc_rdata;
        u  = acc_unpredictable;
    endtask
    task automatic flag(input logic [2:0] n, input logic v);
        @(posedge clk);
        flag_num    <= n;
        flag_write  <= 1'b1;
        flag_wvalue <= v;
        @(posedge clk);
        flag_write  <= 1'b0;
        flag_wvalue <= ~v;
    endtask
endmodule // fp_pipe_model

// ===== bench/fp_register_format_access_bench.sv
// self-checking bench for the formatted float register access block
`timescale 1ns/1ps
module fp_register_format_access_bench;
    import fp_access_pkg::*;
    logic        clk, nrst, read, write, waitrequest, irq, acc_valid, acc_write, acc_done;
    logic        acc_unpredictable, flag_write, flag_wvalue, flag_value, trap, u, ok;
    logic [7:0]  address;
    logic [31:0] writedata, readdata, r, csr;
    logic [3:0]  byteenable, acc_fmt;
    logic [4:0]  acc_num;
    logic [2:0]  flag_num;
    logic [63:0] acc_wdata, acc_rdata, q;
    int          n_fail, n_compared, i;
    fp_register_format_access i_fp_register_format_access (.clk, .nrst, .address, .read, .write, .writedata,
        .byteenable, .readdata, .waitrequest, .irq, .acc_valid, .acc_write, .acc_num, .acc_fmt, .acc_wdata,
        .acc_done, .acc_rdata, .acc_unpredictable, .flag_num, .flag_write, .flag_wvalue, .flag_value, .trap);
    fp_pipe_model i_fp_pipe_model (.clk, .acc_valid, .acc_write, .acc_num, .acc_fmt, .acc_wdata, .acc_done,
        .acc_rdata, .acc_unpredictable, .flag_num, .flag_write, .flag_wvalue);
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compared %0d, wrong %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            n_fail++;
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        @(posedge clk);
        address <= a; read <= !w; write <= w; writedata <= d;
        // waitrequest and readdata are taken at the rising edge that completes the transfer
        for (k = 0; k < 16; k++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        if (k == 16) begin
            n_fail++;
            wrap_up();
        end
        r = readdata;
        read <= 1'b0;
        write <= 1'b0;
        writedata <= ~d;
        @(negedge clk);
    endtask
    task automatic acc(input logic w, input logic [4:0] n, input logic [3:0] f, input logic [63:0] d);
        i_fp_pipe_model.access(w, n, f, d, q, u, ok);
        if (!ok) begin n_fail++; wrap_up(); end
    endtask
    task automatic wcsr(input logic [31:0] d);
        bus(1'b1, off_csr, d);
        repeat (2) @(posedge clk);
        @(negedge clk);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        nrst = 1'b0; read = 1'b0; write = 1'b0; address = '0; writedata = '0; byteenable = 4'hF;
        n_fail = 0; n_compared = 0;
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        acc(1'b1, 5'd2, fmt_double, 64'h1111_2222_3333_4444);
        acc(1'b0, 5'd2, fmt_single, '0); chk(q[31:0], 32'h3333_4444);
        acc(1'b0, 5'd3, fmt_raw_word, '0); chk(q[31:0], 32'h1111_2222);
        acc(1'b0, 5'd2, fmt_raw_double, '0); chk(q, 64'h1111_2222_3333_4444);
        acc(1'b1, 5'd4, fmt_word, 64'hAAAA_BBBB_CCCC_DDDD);
        acc(1'b0, 5'd4, fmt_word, '0); chk(q[31:0], 32'hCCCC_DDDD);
        $display("test pair mode done");
        acc(1'b0, 5'd5, fmt_double, '0); chk(u, 1);
        acc(1'b1, 5'd2, fmt_long, '0); chk(u, 1);
        acc(1'b0, 5'd2, 4'hF, '0); chk(u, 1);
        acc(1'b0, 5'd2, fmt_double, '0); chk(q, 64'h1111_2222_3333_4444);
        bus(1'b0, off_irq_status, '0); chk(r, 32'h0000_0002); chk(irq, 0);
        bus(1'b1, off_irq_mask, 32'h0000_0002); chk(irq, 1);
        bus(1'b1, off_irq_status, 32'h0000_0002); chk(irq, 0);
        bus(1'b0, 8'h20, '0); chk(r, 0);
        $display("test refusals done");
        bus(1'b1, off_mode, 32'h0000_0001);
        acc(1'b1, 5'd7, fmt_long, 64'h0123_4567_89AB_CDEF);
        acc(1'b0, 5'd7, fmt_long, '0); chk(q, 64'h0123_4567_89AB_CDEF);
        acc(1'b1, 5'd9, fmt_double, 64'hFEDC_BA98_7654_3210);
        acc(1'b0, 5'd9, fmt_double, '0); chk(q, 64'hFEDC_BA98_7654_3210);
        $display("test wide mode done");
        for (i = 0; i < 5; i++) begin
            wcsr(32'(1) << (12 + i) | 32'(1) << (7 + i)); chk(trap, 1);
            wcsr(32'(1) << (12 + i)); chk(trap, 0);
        end
        wcsr(32'h0002_0000); chk(trap, 1);
        wcsr(32'h0000_0000); chk(trap, 0);
        $display("test trap done");
        csr = '0;
        for (i = 0; i < 8; i++) begin
            i_fp_pipe_model.flag(3'(i), 1'b1);
            csr = csr | 32'(1) << (i == 0 ? 23 : 24 + i);
            bus(1'b0, off_csr, '0); chk(r, csr);
            chk(flag_value, 1);
        end
        i_fp_pipe_model.flag(3'd3, 1'b0);
        bus(1'b0, off_csr, '0); chk(r, csr & ~32'h0800_0000);
        chk(flag_value, 0);
        $display("test flags done");
        wrap_up();
    end
endmodule // fp_register_format_access_bench
